/* adcimm_ctrl.sv */
// AHB-Lite register block: converter interrupt mask, mode control and sticky status
//
// Operation
// - mask register resets to zero, all blocked
// - mask bit gates same-position status flag
// - mask bit six gates general event
// - mask bit five gates accumulator threshold
// - mask bit four gates current threshold
// - mask bit three gates current overrange
// - mask bits two..zero gate ready flags
// - mode register resets to three
// - mode write resets converters, clears status
// - no result until filter settles again
// - always-interrupt may interrupt before settling
// - always-interrupt fires one period after start
// - mode field selects operating mode
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module adcimm_ctrl #(
    parameter int SETTLE_CYCLES = adcimm_pkg::SETTLE_CYCLES    // filter settling in hclk cycles
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [6:0]  conv_events,       // one-cycle event pulses, status layout
    input  wire logic        conv_period_tick,  // one output period after a conversion start
    output logic             conv_reset,        // one-cycle reset pulse to the converters
    output logic      [2:0]  conv_mode,         // converter_mode_select
    output logic             conv_always_int,   // always_interrupt setting
    output logic             filter_settled,    // filter settled since the last mode write
    output logic             conv_irq           // level interrupt
);

    // whole register state of the block
    typedef struct packed {
        logic [7:0]  mask;                      // converter_irq_mask
        logic [7:0]  mode;                      // converter_mode_ctrl
        logic [7:0]  status;                    // converter_status_flags
        logic        irq;                       // registered interrupt level
        logic        rst_pulse;                 // converter reset pulse
        logic        wr_pend;                   // write data phase pending
        logic [31:0] wr_addr;                   // address of the pending write
        logic [31:0] rdata;                     // read data for the data phase
        logic        ready;                     // hreadyout
        logic        resp;                      // hresp
    } adcimm_state_t;

    localparam adcimm_state_t ST_RST = '{
        mask:      adcimm_pkg::MASK_RST,
        mode:      adcimm_pkg::MODE_RST,
        status:    adcimm_pkg::STATUS_RST,
        irq:       1'b0,
        rst_pulse: 1'b0,
        wr_pend:   1'b0,
        wr_addr:   32'h00000000,
        rdata:     32'h00000000,
        ready:     1'b1,
        resp:      1'b0
    };

    adcimm_state_t st_ff;                       // registered state
    adcimm_state_t nxt_st;                      // next state
    logic          settled;                     // from the settling timer
    logic          addr_ok;                     // valid address phase this cycle
    logic          mode_wr;                     // data phase of a mode write
    logic          mask_wr;                     // data phase of a mask write
    logic          clr_wr;                      // data phase of a status clear write
    logic [7:0]    evt_set;                     // status bits to set this cycle
    logic [7:0]    evt_clr;                     // status bits software clears
    logic [7:0]    rd_val;                      // read mux result

    // settling timer: a mode write restarts the digital filter
    adcimm_settle #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .restart (mode_wr),
        .settled (settled)
    );

    // bus decode, register writes, sticky status and read mux
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.rst_pulse = 1'b0;
        nxt_st.ready     = 1'b1;                // zero wait states, never stalls
        nxt_st.resp      = 1'b0;                // always OKAY

        // only whole-word transfers are decoded; others act as unmapped
        addr_ok = hsel && hready && htrans[adcimm_pkg::HTRANS_ACT_BIT]
                  && (hsize == adcimm_pkg::HSIZE_WORD);

        // data-phase write strobes
        mode_wr = st_ff.wr_pend && (st_ff.wr_addr == adcimm_pkg::ADDR_MODE_CTRL);
        mask_wr = st_ff.wr_pend && (st_ff.wr_addr == adcimm_pkg::ADDR_IRQ_MASK);
        clr_wr  = st_ff.wr_pend && (st_ff.wr_addr == adcimm_pkg::ADDR_STATUS_CLR);

        // converter events; result ready only counts once the filter settled
        evt_set = {1'b0, conv_events};
        if (!settled || mode_wr)
        begin
            evt_set = evt_set & ~{1'b0, adcimm_pkg::READY_FLAGS};
        end
        // always-interrupt gives the general event even while unsettled
        if (st_ff.mode[adcimm_pkg::BIT_ALWAYS_INT] && conv_period_tick)
        begin
            evt_set[adcimm_pkg::BIT_GEN_EVT] = 1'b1;
        end
        evt_set = evt_set & adcimm_pkg::STATUS_WMASK;

        // write-one-to-clear of status
        evt_clr = clr_wr ? hwdata[7:0] : 8'h00;

        // mask register; the reserved top bit is never stored
        if (mask_wr)
        begin
            nxt_st.mask = hwdata[7:0] & adcimm_pkg::MASK_WMASK;
        end

        if (mode_wr)
        begin
            // the write resets the converters; flags of the old setup are discarded,
            // so here the clear wins over an event arriving in the same cycle
            nxt_st.mode      = hwdata[7:0] & adcimm_pkg::MODE_WMASK;
            nxt_st.rst_pulse = 1'b1;
            nxt_st.status    = adcimm_pkg::STATUS_RST;
        end
        else
        begin
            // sticky flags: a set in the clearing cycle wins
            nxt_st.status = (st_ff.status & ~evt_clr) | evt_set;
        end

        // interrupt level follows the masked flags
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);

        // address phase: remember writes, prepare read data now
        nxt_st.wr_pend = addr_ok && hwrite;
        // the address is captured every cycle; only wr_pend decides whether it is used
        nxt_st.wr_addr = haddr;

        // read mux uses next values so a read right after a write sees it
        // unmapped and non-word reads return zero with an okay response
        unique case (haddr)
            adcimm_pkg::ADDR_IRQ_MASK:  rd_val = nxt_st.mask;
            adcimm_pkg::ADDR_MODE_CTRL: rd_val = nxt_st.mode;
            adcimm_pkg::ADDR_STATUS:    rd_val = nxt_st.status;
            default:                    rd_val = 8'h00;     // clear reg and unmapped
        endcase
        nxt_st.rdata = (addr_ok && !hwrite) ? {24'h000000, rd_val} : 32'h00000000;
    end

    // state register
    // one register for all state keeps the reset branch to a single constant
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    // outputs, all straight from flip-flops
    // ready and response are constant flops, kept so a wait state can be added later
    assign hrdata          = st_ff.rdata;
    assign hreadyout       = st_ff.ready;
    assign hresp           = st_ff.resp;
    assign conv_reset      = st_ff.rst_pulse;
    assign conv_mode       = st_ff.mode[adcimm_pkg::MODE_SEL_MSB:0];
    assign conv_always_int = st_ff.mode[adcimm_pkg::BIT_ALWAYS_INT];
    assign filter_settled  = settled;
    assign conv_irq        = st_ff.irq;

    // checks on the block's own behaviour
    // they watch the registered state, so each rule shows one edge after its cause;
    // the reset checks override the default disable to look inside reset
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // steps of a mode write
    sequence mode_wr_s;
        mode_wr;
    endsequence

    sequence mode_applied_s;
        st_ff.rst_pulse && (st_ff.status == 8'h00) && !settled;
    endsequence

    sequence reset_values_s;
        (st_ff.mask == adcimm_pkg::MASK_RST) && (st_ff.mode == adcimm_pkg::MODE_RST);
    endsequence

    mask_reset_zero_a: assert property (
        disable iff (1'b0) !hresetn |=> reset_values_s ##0 !conv_irq)
        else $error("mask or mode not at reset value after reset");

    mode_reset_three_a: assert property (
        disable iff (1'b0) !hresetn |=> (conv_mode == adcimm_pkg::ADCIMM_MD_IDLE))
        else $error("mode field not idle after reset");

    irq_or_masked_a: assert property (
        conv_irq == |(st_ff.status & st_ff.mask))
        else $error("interrupt does not match masked flags");

    irq_blocked_a: assert property (
        ((st_ff.status & st_ff.mask) == 8'h00) |-> !conv_irq)
        else $error("interrupt raised with every flag masked");

    gen_event_irq_a: assert property (
        (st_ff.status[adcimm_pkg::BIT_GEN_EVT] && st_ff.mask[adcimm_pkg::BIT_GEN_EVT])
        |-> conv_irq)
        else $error("general event not signalled");

    accum_thr_irq_a: assert property (
        (st_ff.status[adcimm_pkg::BIT_ACC_THR] && st_ff.mask[adcimm_pkg::BIT_ACC_THR])
        |-> conv_irq)
        else $error("accumulator threshold not signalled");

    cur_thr_irq_a: assert property (
        (st_ff.status[adcimm_pkg::BIT_CUR_THR] && st_ff.mask[adcimm_pkg::BIT_CUR_THR])
        |-> conv_irq)
        else $error("current threshold not signalled");

    overrange_irq_a: assert property (
        (st_ff.status[adcimm_pkg::BIT_CUR_OVR] && st_ff.mask[adcimm_pkg::BIT_CUR_OVR])
        |-> conv_irq)
        else $error("overrange not signalled");

    ready_irq_a: assert property (
        ((st_ff.status[2:0] & st_ff.mask[2:0]) != 3'h0) |-> conv_irq)
        else $error("result ready not signalled");

    mask_store_a: assert property (
        mask_wr |=> (st_ff.mask == ($past(hwdata[7:0]) & adcimm_pkg::MASK_WMASK)))
        else $error("mask write not stored");

    mode_write_reset_a: assert property (
        mode_wr_s |=> mode_applied_s ##1 (!st_ff.rst_pulse || $past(mode_wr)))
        else $error("mode write did not reset converters");

    unsettled_ready_a: assert property (
        (!settled && (st_ff.status[2:0] == 3'h0)) |=> (st_ff.status[2:0] == 3'h0))
        else $error("result ready set before filter settled");

    always_int_a: assert property (
        (conv_always_int && conv_period_tick && !mode_wr)
        |=> st_ff.status[adcimm_pkg::BIT_GEN_EVT])
        else $error("always interrupt did not raise general event");

    mode_select_a: assert property (
        mode_wr |=> (conv_mode == $past(hwdata[2:0])) && (st_ff.mode[7:6] == 2'h0))
        else $error("mode field not taken from write");

    set_beats_clear_a: assert property (
        (clr_wr && hwdata[adcimm_pkg::BIT_CUR_OVR] && conv_events[adcimm_pkg::BIT_CUR_OVR])
        |=> st_ff.status[adcimm_pkg::BIT_CUR_OVR])
        else $error("event lost against clear");

    // the converter reset is exactly the registered mode write strobe
    reset_pulse_a: assert property (
        conv_reset == $past(mode_wr))
        else $error("converter reset pulse does not follow mode write");

    // the filter stays unsettled for at least two cycles after any mode write
    settle_low_a: assert property (
        mode_wr |=> !filter_settled [*2])
        else $error("filter reported settled right after mode write");

    // with always-interrupt off a tick alone never raises the general event
    always_off_a: assert property (
        (!conv_always_int && conv_period_tick && !conv_events[adcimm_pkg::BIT_GEN_EVT]
         && !st_ff.status[adcimm_pkg::BIT_GEN_EVT])
        |=> !st_ff.status[adcimm_pkg::BIT_GEN_EVT])
        else $error("general event raised by tick with always interrupt off");

    // the level stays up while a masked flag stands and nothing clears it
    irq_holds_a: assert property (
        (conv_irq && !mode_wr && !clr_wr && !mask_wr) |=> conv_irq)
        else $error("interrupt dropped while a masked flag stands");

    // zero wait states and an okay response on every cycle
    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or answered with an error");

    // read data is driven only in the data phase of a read
    rdata_idle_a: assert property (
        !(addr_ok && !hwrite) |=> (hrdata == 32'h00000000))
        else $error("read data not zero outside a read data phase");

endmodule

/* adcimm_pkg.sv */
// shared constants and types for the converter interrupt mask and mode block
package adcimm_pkg;

    // bus geometry
    localparam int          ADDR_W          = 32;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 8;
    localparam int          EVT_W           = 7;
    localparam int          HTRANS_ACT_BIT  = 1;            // set for NONSEQ and SEQ
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    // register byte addresses
    localparam logic [31:0] ADDR_IRQ_MASK   = 32'h40030004; // converter_irq_mask
    localparam logic [31:0] ADDR_MODE_CTRL  = 32'h40030008; // converter_mode_ctrl
    localparam logic [31:0] ADDR_STATUS     = 32'h40030040; // converter_status_flags, read only
    localparam logic [31:0] ADDR_STATUS_CLR = 32'h40030044; // write one to clear, reads zero

    // reset values
    localparam logic [7:0]  MASK_RST        = 8'h00;
    localparam logic [7:0]  MODE_RST        = 8'h03;
    localparam logic [7:0]  STATUS_RST      = 8'h00;

    // writable bits; reserved bits are stored as zero
    localparam logic [7:0]  MASK_WMASK      = 8'h7F;
    localparam logic [7:0]  MODE_WMASK      = 8'h2F;
    localparam logic [7:0]  STATUS_WMASK    = 8'h7F;

    // status and mask bit positions
    localparam int          BIT_CUR_RDY     = 0;            // current_result_ready
    localparam int          BIT_VOLT_RDY    = 1;            // voltage_result_ready
    localparam int          BIT_AUX_RDY     = 2;            // aux_result_ready
    localparam int          BIT_CUR_OVR     = 3;            // current_overrange
    localparam int          BIT_CUR_THR     = 4;            // current_threshold_hit
    localparam int          BIT_ACC_THR     = 5;            // current_accum_threshold_hit
    localparam int          BIT_GEN_EVT     = 6;            // general_converter_event
    localparam logic [6:0]  READY_FLAGS     = 7'h07;        // result_ready_flags

    // mode register fields
    localparam int          BIT_ALWAYS_INT  = 5;            // always_interrupt
    localparam int          MODE_SEL_MSB    = 2;            // converter_mode_select [2:0]

    // settling time of the digital filter
    localparam int          CLK_PERIOD_PS   = 8000;         // 125 MHz hclk
    localparam int          SETTLE_TIME_NS  = 20;
    localparam int          SETTLE_CYCLES   =
        (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // converter_mode_select encodings
    typedef enum logic [2:0] {
        ADCIMM_MD_POWER_DOWN = 3'h0,
        ADCIMM_MD_CONTINUOUS = 3'h1,
        ADCIMM_MD_SINGLE     = 3'h2,
        ADCIMM_MD_IDLE       = 3'h3,
        ADCIMM_MD_CAL_OFFS   = 3'h4,
        ADCIMM_MD_CAL_GAIN   = 3'h5,
        ADCIMM_MD_CAL_SYS_Z  = 3'h6,
        ADCIMM_MD_CAL_SYS_F  = 3'h7
    } adcimm_mode_t;

endpackage

/* adcimm_settle.sv */
// filter settling timer, restarted by every mode register write
`timescale 1ns/1ps
module adcimm_settle #(
    parameter int CYCLES = adcimm_pkg::SETTLE_CYCLES    // settling time in hclk cycles
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic restart,
    output logic      settled
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;                          // cycles left to settle
        logic             done;                         // filter settled
    } adcimm_settle_t;

    localparam adcimm_settle_t ST_RST = '{cnt: CNT_LOAD, done: 1'b0};

    adcimm_settle_t st_ff;                              // registered state
    adcimm_settle_t nxt_st;                             // next state

    // reload on restart, otherwise count down; settled only once the count is spent
    always_comb
    begin
        nxt_st = st_ff;
        if (restart)
        begin
            nxt_st.cnt  = CNT_LOAD;
            nxt_st.done = 1'b0;
        end
        else if (st_ff.cnt != '0)
        begin
            nxt_st.cnt  = st_ff.cnt - CNT_ONE;
            nxt_st.done = 1'b0;
        end
        else
        begin
            nxt_st.done = 1'b1;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    assign settled = st_ff.done;
endmodule

/* adcimm_ctrl_bench.sv */
// self-checking bench for the converter interrupt mask and mode register block
`timescale 1ns/1ps
module adcimm_ctrl_bench;
    localparam int P_SETTLE = 8;           // longer than default so the unsettled window shows
    logic        hclk;                     // bus clock, 8 ns
    logic        hresetn;                  // async reset, active low
    logic        hsel;                     // slave select
    logic [31:0] haddr;                    // byte address
    logic [1:0]  htrans;                   // transfer type
    logic        hwrite;                   // write strobe
    logic [2:0]  hsize;                    // transfer size
    logic [31:0] hwdata;                   // write data
    logic [31:0] hrdata;                   // read data
    logic        hreadyout;                // slave ready, also the bus hready
    logic        hresp;                    // response
    logic [6:0]  conv_events;              // event pulses in status layout
    logic        conv_period_tick;         // output period tick
    logic        conv_reset;               // converter reset pulse
    logic [2:0]  conv_mode;                // selected mode
    logic        conv_always_int;          // always-interrupt setting
    logic        filter_settled;           // settling done
    logic        conv_irq;                 // level interrupt
    logic [31:0] rdat;                     // scratch read value
    int          n_errors;                 // mismatches
    int          n_tests;                  // comparisons

    adcimm_ctrl #(.SETTLE_CYCLES(P_SETTLE)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .conv_events(conv_events), .conv_period_tick(conv_period_tick),
        .conv_reset(conv_reset), .conv_mode(conv_mode), .conv_always_int(conv_always_int),
        .filter_settled(filter_settled), .conv_irq(conv_irq));

    // free-running clock
    always #4 hclk = ~hclk;

    // compare one value, count it and report a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single AHB-Lite transfer; starts at the next rising edge, waits on hready
    // with no cycle count assumed, returns 1 ns after the data phase so outputs settled
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= adcimm_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(hresp, 0);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rdat);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000, rdat);
        check(rdat, exp);
    endtask

    // one-cycle event and tick pulse; returns just after the edge that takes it
    task automatic pulse(input logic [6:0] ev, input logic tick);
        @(posedge hclk);
        conv_events      <= ev;
        conv_period_tick <= tick;
        @(posedge hclk);
        conv_events      <= 7'h00;
        conv_period_tick <= 1'b0;
        #1;
    endtask

    // bounded wait for the settling flag; ready events are dropped before it
    task automatic wait_settled();
        int guard;
        guard = 0;
        while (filter_settled !== 1'b1 && guard < 64)
        begin
            @(posedge hclk);
            guard++;
        end
        check(filter_settled, 1);
    endtask

    task automatic t_reset();
        rd_chk(adcimm_pkg::ADDR_IRQ_MASK, 32'h00000000);
        rd_chk(adcimm_pkg::ADDR_MODE_CTRL, 32'h00000003);
        check(conv_mode, 3'h3);
        wait_settled();
        pulse(7'h7F, 1'b0);
        check(conv_irq, 0);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h0000007F);
        wr(adcimm_pkg::ADDR_STATUS_CLR, 32'h0000007F);
        $display("test reset done");
    endtask

    // each mask bit lets only its own flag through, and the level holds until cleared
    task automatic t_gate();
        logic [6:0] bit_v;
        for (int b = 0; b < 7; b++)
        begin
            bit_v = 7'h01 << b;
            wr(adcimm_pkg::ADDR_IRQ_MASK, {25'h0, bit_v});
            pulse(~bit_v, 1'b0);
            check(conv_irq, 0);
            pulse(bit_v, 1'b0);
            check(conv_irq, 1);
            rd_chk(adcimm_pkg::ADDR_STATUS, 32'h0000007F);
            check(conv_irq, 1);
            wr(adcimm_pkg::ADDR_STATUS_CLR, 32'h0000007F);
            #1;
            check(conv_irq, 0);
        end
        $display("test gate done");
    endtask

    // all writable bits read back as written; every mode code reaches the converters
    task automatic t_fields();
        wr(adcimm_pkg::ADDR_IRQ_MASK, 32'h0000007F);
        rd_chk(adcimm_pkg::ADDR_IRQ_MASK, 32'h0000007F);
        wr(adcimm_pkg::ADDR_MODE_CTRL, 32'h0000002F);
        rd_chk(adcimm_pkg::ADDR_MODE_CTRL, 32'h0000002F);
        for (int m = 0; m < 8; m++)
        begin
            wr(adcimm_pkg::ADDR_MODE_CTRL, m);
            check(conv_mode, m);
            rd_chk(adcimm_pkg::ADDR_MODE_CTRL, m);
        end
        $display("test fields done");
    endtask

    // a mode write resets converters, wipes status and restarts settling
    task automatic t_mode_reset();
        wr(adcimm_pkg::ADDR_MODE_CTRL, 32'h00000001);
        wr(adcimm_pkg::ADDR_IRQ_MASK, 32'h0000007F);
        wait_settled();
        pulse(7'h7F, 1'b0);
        check(conv_irq, 1);
        wr(adcimm_pkg::ADDR_MODE_CTRL, 32'h00000002);
        #1;
        check(conv_reset, 1);
        check(filter_settled, 0);
        check(conv_irq, 0);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000000);
        pulse(7'h07, 1'b0);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000000);
        wait_settled();
        pulse(7'h01, 1'b0);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000001);
        wr(adcimm_pkg::ADDR_STATUS_CLR, 32'h0000007F);
        $display("test mode reset done");
    endtask

    // the always-interrupt tick raises the general event before settling
    task automatic t_always();
        wr(adcimm_pkg::ADDR_IRQ_MASK, 32'h00000040);
        wr(adcimm_pkg::ADDR_MODE_CTRL, 32'h00000021);
        check(conv_always_int, 1);
        pulse(7'h00, 1'b1);
        check(filter_settled, 0);
        check(conv_irq, 1);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000040);
        wr(adcimm_pkg::ADDR_MODE_CTRL, 32'h00000001);
        check(conv_always_int, 0);
        pulse(7'h00, 1'b1);
        check(conv_irq, 0);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000000);
        $display("test always interrupt done");
    endtask

    // an unmapped write is dropped and reads back zero
    task automatic t_unmapped();
        wr(32'h40030010, 32'h00000055);
        rd_chk(32'h40030010, 32'h00000000);
        rd_chk(adcimm_pkg::ADDR_IRQ_MASK, 32'h00000040);
        $display("test unmapped done");
    endtask

    // a clear that meets a new overrange event in the same cycle leaves it set
    task automatic t_set_wins();
        fork
            wr(adcimm_pkg::ADDR_STATUS_CLR, 32'h00000008);
            begin
                @(posedge hclk);
                pulse(7'h08, 1'b0);
            end
        join
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000008);
        wr(adcimm_pkg::ADDR_STATUS_CLR, 32'h00000008);
        rd_chk(adcimm_pkg::ADDR_STATUS, 32'h00000000);
        $display("test set wins done");
    endtask

    // single exit point for normal end and for the watchdog
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        hclk             = 1'b0;
        hresetn          = 1'b0;
        hsel             = 1'b0;
        haddr            = 32'h00000000;
        htrans           = 2'h0;
        hwrite           = 1'b0;
        hsize            = 3'h2;
        hwdata           = 32'h00000000;
        conv_events      = 7'h00;
        conv_period_tick = 1'b0;
        n_errors         = 0;
        n_tests          = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_gate();
        t_fields();
        t_mode_reset();
        t_always();
        t_unmapped();
        t_set_wins();
        print_verdict();
    end

    // watchdog: the tests need well under 2000 cycles, so 25000 means a hang
    initial
    begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule
